// ### pkg/adcsc_pkg.sv
// shared constants, types and register map of the converter sequencer and compute block
package adcsc_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_CTRL0    = 8'h00;
  localparam logic [7:0] OFF_CTRL1    = 8'h04;
  localparam logic [7:0] OFF_CTRL2    = 8'h08;
  localparam logic [7:0] OFF_PRE      = 8'h0C;
  localparam logic [7:0] OFF_ACQ      = 8'h10;
  localparam logic [7:0] OFF_RPT      = 8'h14;
  localparam logic [7:0] OFF_THLO     = 8'h18;
  localparam logic [7:0] OFF_THHI     = 8'h1C;
  localparam logic [7:0] OFF_STATUS   = 8'h20;
  localparam logic [7:0] OFF_RESULT   = 8'h24;
  localparam logic [7:0] OFF_ACC      = 8'h28;
  localparam logic [7:0] OFF_COUNT    = 8'h2C;

  // control zero fields
  localparam int CTRL0_GO_BIT         = 0;
  localparam int CTRL0_TRIG_EN_BIT    = 1;

  // control two fields
  localparam int CTRL2_MODE_LSB       = 0;
  localparam int CTRL2_THR_LSB        = 4;
  localparam int CTRL2_SHIFT_LSB      = 8;

  // status fields
  localparam int STAT_CONV_BIT        = 0;
  localparam int STAT_THR_BIT         = 1;
  localparam int STAT_BUSY_BIT        = 2;
  localparam int STAT_SECOND_BIT      = 3;

  // widths and timing
  localparam int TIME_W               = 13;
  localparam int RES_W                = 12;
  localparam int ACC_W                = 18;
  localparam int CNT_W                = 8;
  localparam int ACQ_MAX_CYCLES       = 8191;

  // reset values
  localparam logic [TIME_W-1:0] PRE_RST  = 13'h0000;
  localparam logic [TIME_W-1:0] ACQ_RST  = 13'h0000;
  localparam logic [CNT_W-1:0]  RPT_RST  = 8'h00;
  localparam logic [ACC_W-1:0]  THR_RST  = 18'h00000;
  localparam logic [2:0]        MODE_RST = 3'h0;

  // computation mode codes
  localparam logic [2:0] MODE_BASIC   = 3'h0;
  localparam logic [2:0] MODE_ACCUM   = 3'h1;
  localparam logic [2:0] MODE_AVG     = 3'h2;
  localparam logic [2:0] MODE_BURST   = 3'h3;
  localparam logic [2:0] MODE_LPF     = 3'h4;

  // threshold test codes
  localparam logic [2:0] THR_NEVER    = 3'h0;
  localparam logic [2:0] THR_BELOW    = 3'h1;
  localparam logic [2:0] THR_ABOVE    = 3'h2;
  localparam logic [2:0] THR_OUTSIDE  = 3'h3;
  localparam logic [2:0] THR_INSIDE   = 3'h4;

  // control one register layout, bit 3 down to bit 0
  typedef struct packed {
    logic second_sample_invert;
    logic double_sample_enable;
    logic guard_polarity;
    logic charge_level_select;
  } adcsc_cfg_t;

  localparam adcsc_cfg_t CFG_RST = '{default: 1'b0};

endpackage

// ### hdl/adcsc_top.sv
// converter precharge/acquisition sequencer, guard outputs and post-conversion compute with apb registers
//
// Behaviour
// - nonzero precharge length register enables the precharge phase.
// - precharge begins at every conversion start: go bit, special trigger, restart.
// - precharge length zero at conversion start skips precharge altogether.
// - during precharge hold capacitor leaves outer path, tied to rail by level bit.
// - during precharge channel pin driven to level bit, overriding pin direction.
// - precharge lasts as many cycles as the precharge length register holds.
// - acquisition starts at conversion start or after precharge; length from acquisition register.
// - acquisition start releases pin drivers and connects channel to hold capacitor.
// - precharge enabled and acquisition zero gives 8191 cycle acquisition.
// - precharge disabled and acquisition zero means no timed acquisition.
// - first precharge start sets both guard outputs to guard polarity.
// - acquisition start inverts guard A, guard B unchanged.
// - double sample with invert: both guards inverse at second precharge, A toggles again.
// - three-bit mode field in control two selects among five compute modes.
// - basic mode converts one or two samples; flag set after all samples.
// - accumulate mode adds result, counts, sets flag, tests threshold per setting.
// - average mode accumulates to repeat target, tests, restarts set on next trigger.
// - burst mode clears on trigger, converts repeatedly to repeat target, then tests.
// - filter mode filters each result, tests at repeat target and every trigger after.
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps

module adcsc_top
  import adcsc_pkg::*;
#(
  parameter int ACQ_MAX = ACQ_MAX_CYCLES
)
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              reset_n,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [31:0]            prdata,
  // conversion triggers
  input  wire logic              special_trigger,
  // converter core
  output logic                   conv_start,
  input  wire logic              conv_done,
  input  wire logic [RES_W-1:0]  conv_result,
  // sample path
  output logic                   hold_to_rail,
  output logic                   hold_rail_high,
  output logic                   hold_to_channel,
  // channel pin
  input  wire logic              pin_direction,
  input  wire logic              pin_port_data,
  output logic                   pin_out,
  output logic                   pin_oe,
  // guard ring
  output logic                   guard_out_a,
  output logic                   guard_out_b
);

  typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_ACQ, ST_CONV} adcsc_state_t;

  // software registers
  logic                go_q;
  logic                trig_en_q;
  adcsc_cfg_t          cfg_q;
  logic [2:0]          compute_mode_select_q;
  logic [2:0]          thr_mode_q;
  logic [2:0]          shift_q;
  logic [TIME_W-1:0]   pre_len_q;
  logic [TIME_W-1:0]   acquisition_time_q;
  logic [CNT_W-1:0]    repeat_target_q;
  logic [ACC_W-1:0]    thr_lo_q;
  logic [ACC_W-1:0]    thr_hi_q;
  logic                conversion_flag_q;
  logic                threshold_flag_q;
  logic [31:0]         prdata_q;

  // sequencer and compute state
  adcsc_state_t        state_q;
  logic [TIME_W-1:0]   timer_q;
  logic                second_q;
  logic                conv_start_q;
  logic                guard_a_q;
  logic                guard_b_q;
  logic [RES_W-1:0]    result_q;
  logic [ACC_W-1:0]    acc_q;
  logic [CNT_W-1:0]    accumulated_count_q;

  // saturating counter step
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (v == {CNT_W{1'b1}}) ? v : v + 8'h01;
  endfunction

  // threshold comparison against the window registers
  function automatic logic thr_hit(input logic [2:0] m, input logic [ACC_W-1:0] v,
                                   input logic [ACC_W-1:0] lo, input logic [ACC_W-1:0] hi);
    case (m)
      THR_NEVER:   thr_hit = 1'b0;
      THR_BELOW:   thr_hit = v < lo;
      THR_ABOVE:   thr_hit = v > hi;
      THR_OUTSIDE: thr_hit = (v < lo) || (v > hi);
      THR_INSIDE:  thr_hit = (v >= lo) && (v <= hi);
      default:     thr_hit = 1'b1;
    endcase
  endfunction

  // apb decode
  wire         setup_ph   = psel && !penable;
  wire         access_ph  = psel && penable;
  wire         wr_en      = access_ph && pwrite;
  wire         hit_ctrl0  = paddr == OFF_CTRL0;
  wire         hit_ctrl1  = paddr == OFF_CTRL1;
  wire         hit_ctrl2  = paddr == OFF_CTRL2;
  wire         hit_pre    = paddr == OFF_PRE;
  wire         hit_acq    = paddr == OFF_ACQ;
  wire         hit_rpt    = paddr == OFF_RPT;
  wire         hit_thlo   = paddr == OFF_THLO;
  wire         hit_thhi   = paddr == OFF_THHI;
  wire         hit_status = paddr == OFF_STATUS;
  wire         hit_result = paddr == OFF_RESULT;
  wire         hit_acc    = paddr == OFF_ACC;
  wire         hit_count  = paddr == OFF_COUNT;
  wire         hit_any    = hit_ctrl0 || hit_ctrl1 || hit_ctrl2 || hit_pre || hit_acq || hit_rpt ||
                            hit_thlo || hit_thhi || hit_status || hit_result || hit_acc || hit_count;

  // sequencer decode
  wire         busy       = state_q != ST_IDLE;
  wire         go_write   = wr_en && hit_ctrl0 && pwdata[CTRL0_GO_BIT];
  wire         trigger    = !busy && (go_write || (trig_en_q && special_trigger));
  wire         pre_en     = pre_len_q != PRE_RST;
  wire         acq_zero   = acquisition_time_q == ACQ_RST;
  wire [TIME_W-1:0] acq_load = acq_zero ? ACQ_MAX[TIME_W-1:0] : acquisition_time_q;
  wire         timer_end  = timer_q == 13'h0001;
  wire         need_second = cfg_q.double_sample_enable && !second_q;
  wire         set_done   = (state_q == ST_CONV) && conv_done && !need_second;

  // compute datapath
  wire [CNT_W-1:0]  rpt_eff   = (repeat_target_q == RPT_RST) ? 8'h01 : repeat_target_q;
  wire [ACC_W-1:0]  sample    = {6'h00, conv_result};
  wire [ACC_W-1:0]  acc_add   = acc_q + sample;
  wire [ACC_W-1:0]  acc_lpf   = acc_q - (acc_q >> shift_q) + sample;
  wire              avg_fresh = accumulated_count_q >= rpt_eff;
  wire [CNT_W-1:0]  cnt_inc   = sat_inc(accumulated_count_q);
  logic [ACC_W-1:0] acc_new;
  logic [CNT_W-1:0] cnt_new;
  logic             test_now;
  logic             flag_now;
  logic             restart;

  always_comb
  begin
    acc_new  = acc_q;
    cnt_new  = accumulated_count_q;
    test_now = 1'b0;
    flag_now = 1'b1;
    restart  = 1'b0;
    case (compute_mode_select_q)
      MODE_BASIC:
      begin
        test_now = 1'b1;
      end
      MODE_ACCUM:
      begin
        acc_new  = acc_add;
        cnt_new  = cnt_inc;
        test_now = 1'b1;
      end
      MODE_AVG:
      begin
        acc_new  = avg_fresh ? sample : acc_add;
        cnt_new  = avg_fresh ? 8'h01 : cnt_inc;
        test_now = cnt_new == rpt_eff;
      end
      MODE_BURST:
      begin
        acc_new  = acc_add;
        cnt_new  = cnt_inc;
        test_now = cnt_new >= rpt_eff;
        flag_now = test_now;
        restart  = !test_now;
      end
      MODE_LPF:
      begin
        acc_new  = acc_lpf;
        cnt_new  = cnt_inc;
        test_now = cnt_new >= rpt_eff;
      end
      default:
      begin
        flag_now = 1'b0;
      end
    endcase
  end

  wire [ACC_W-1:0] test_val  = (compute_mode_select_q == MODE_BASIC) ? sample : acc_new;
  wire             thr_event = set_done && test_now && thr_hit(thr_mode_q, test_val, thr_lo_q, thr_hi_q);
  wire             conv_event = set_done && flag_now;
  wire             restart_now = set_done && restart;
  wire             start_first = trigger || restart_now;
  wire             start_second = (state_q == ST_CONV) && conv_done && need_second;
  wire             start_any = start_first || start_second;
  wire             second_next = start_second;

  // phase chosen when a sample begins
  wire             to_pre    = start_any && pre_en;
  wire             to_acq_0  = start_any && !pre_en && !acq_zero;
  wire             to_conv_0 = start_any && !pre_en && acq_zero;
  wire             pre_over  = (state_q == ST_PRE) && timer_end;
  wire             acq_over  = (state_q == ST_ACQ) && timer_end;
  wire             acq_begin = to_acq_0 || pre_over;
  wire             conv_begin = to_conv_0 || acq_over;
  wire             invert_second = second_next && cfg_q.second_sample_invert;

  // sequencer state and phase timer
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q      <= ST_IDLE;
      timer_q      <= PRE_RST;
      second_q     <= 1'b0;
      conv_start_q <= 1'b0;
    end
    else
    begin
      conv_start_q <= conv_begin;
      if (to_pre)
      begin
        state_q <= ST_PRE;
        timer_q <= pre_len_q;
      end
      else if (acq_begin)
      begin
        state_q <= ST_ACQ;
        timer_q <= acq_load;
      end
      else if (conv_begin)
        state_q <= ST_CONV;
      else if (set_done)
        state_q <= ST_IDLE;
      else if (state_q == ST_PRE || state_q == ST_ACQ)
        timer_q <= timer_q - 13'h0001;
      if (start_any)
        second_q <= second_next;
    end
  end

  // guard ring outputs follow the phase edges
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      guard_a_q <= 1'b0;
      guard_b_q <= 1'b0;
    end
    else if (to_pre)
    begin
      guard_a_q <= invert_second ? !cfg_q.guard_polarity : cfg_q.guard_polarity;
      guard_b_q <= invert_second ? !cfg_q.guard_polarity : cfg_q.guard_polarity;
    end
    else if (acq_begin)
      guard_a_q <= !guard_a_q;
  end

  // accumulator, count and last result
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc_q               <= THR_RST;
      accumulated_count_q <= RPT_RST;
      result_q            <= 12'h000;
    end
    else if (trigger && compute_mode_select_q == MODE_BURST)
    begin
      acc_q               <= THR_RST;
      accumulated_count_q <= RPT_RST;
    end
    else if (set_done)
    begin
      acc_q               <= acc_new;
      accumulated_count_q <= cnt_new;
      result_q            <= conv_result;
    end
    else if (wr_en && hit_acc)
    begin
      acc_q               <= THR_RST;
      accumulated_count_q <= RPT_RST;
    end
    else if ((state_q == ST_CONV) && conv_done)
      result_q            <= conv_result;
  end

  // software control registers
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      trig_en_q             <= 1'b0;
      cfg_q                 <= CFG_RST;
      compute_mode_select_q <= MODE_RST;
      thr_mode_q            <= THR_NEVER;
      shift_q               <= 3'h0;
      pre_len_q             <= PRE_RST;
      acquisition_time_q    <= ACQ_RST;
      repeat_target_q       <= RPT_RST;
      thr_lo_q              <= THR_RST;
      thr_hi_q              <= THR_RST;
    end
    else if (wr_en)
    begin
      if (hit_ctrl0)
        trig_en_q <= pwdata[CTRL0_TRIG_EN_BIT];
      if (hit_ctrl1)
        cfg_q <= adcsc_cfg_t'(pwdata[3:0]);
      if (hit_ctrl2)
      begin
        compute_mode_select_q <= pwdata[CTRL2_MODE_LSB +: 3];
        thr_mode_q            <= pwdata[CTRL2_THR_LSB +: 3];
        shift_q               <= pwdata[CTRL2_SHIFT_LSB +: 3];
      end
      if (hit_pre)
        pre_len_q <= pwdata[TIME_W-1:0];
      if (hit_acq)
        acquisition_time_q <= pwdata[TIME_W-1:0];
      if (hit_rpt)
        repeat_target_q <= pwdata[CNT_W-1:0];
      if (hit_thlo)
        thr_lo_q <= pwdata[ACC_W-1:0];
      if (hit_thhi)
        thr_hi_q <= pwdata[ACC_W-1:0];
    end
  end

  // go bit stays set until the sample set finishes; flags set by hardware beat a clear
  wire clr_conv = wr_en && hit_status && pwdata[STAT_CONV_BIT];
  wire clr_thr  = wr_en && hit_status && pwdata[STAT_THR_BIT];

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      go_q              <= 1'b0;
      conversion_flag_q <= 1'b0;
      threshold_flag_q  <= 1'b0;
    end
    else
    begin
      go_q              <= trigger ? 1'b1 : ((set_done && !restart) ? 1'b0 : go_q);
      conversion_flag_q <= conv_event || (conversion_flag_q && !clr_conv);
      threshold_flag_q  <= thr_event || (threshold_flag_q && !clr_thr);
    end
  end

  // read data captured in the setup cycle, valid through the access cycle
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (1'b1)
      hit_ctrl0:  rd_mux = {30'h0, trig_en_q, go_q};
      hit_ctrl1:  rd_mux = {28'h0, cfg_q};
      hit_ctrl2:  rd_mux = {21'h0, shift_q, 1'b0, thr_mode_q, 1'b0, compute_mode_select_q};
      hit_pre:    rd_mux = {19'h0, pre_len_q};
      hit_acq:    rd_mux = {19'h0, acquisition_time_q};
      hit_rpt:    rd_mux = {24'h0, repeat_target_q};
      hit_thlo:   rd_mux = {14'h0, thr_lo_q};
      hit_thhi:   rd_mux = {14'h0, thr_hi_q};
      hit_status: rd_mux = {28'h0, second_q, busy, threshold_flag_q, conversion_flag_q};
      hit_result: rd_mux = {20'h0, result_q};
      hit_acc:    rd_mux = {14'h0, acc_q};
      hit_count:  rd_mux = {24'h0, accumulated_count_q};
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      prdata_q <= 32'h0000_0000;
    else if (setup_ph && !pwrite)
      prdata_q <= rd_mux;
  end

  // outputs
  wire in_pre = state_q == ST_PRE;

  assign pready          = 1'b1;
  assign pslverr         = access_ph && !hit_any;
  assign prdata          = prdata_q;
  assign conv_start      = conv_start_q;
  assign hold_to_rail    = in_pre;
  assign hold_rail_high  = in_pre && cfg_q.charge_level_select;
  // channel joins the hold capacitor for acquisition and conversion only
  assign hold_to_channel = (state_q == ST_ACQ) || (state_q == ST_CONV);
  // precharge drive wins over the direction bit; released when acquisition starts
  assign pin_oe          = in_pre ? 1'b1 : !pin_direction;
  assign pin_out         = in_pre ? cfg_q.charge_level_select : pin_port_data;
  assign guard_out_a     = guard_a_q;
  assign guard_out_b     = guard_b_q;

endmodule

// ### test/adcsc_top_assertions.sv
// concurrent checks on the sequencer pins of the converter sequencer and compute block
`timescale 1ns/1ps

module adcsc_top_assertions
  import adcsc_pkg::*;
#(
  parameter int ACQ_MAX = ACQ_MAX_CYCLES
)
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // converter core
  input wire logic conv_start,
  input wire logic conv_done,
  // sample path
  input wire logic hold_to_rail,
  input wire logic hold_rail_high,
  input wire logic hold_to_channel,
  // channel pin
  input wire logic pin_direction,
  input wire logic pin_port_data,
  input wire logic pin_out,
  input wire logic pin_oe,
  // guard ring
  input wire logic guard_out_a,
  input wire logic guard_out_b
);
  logic [13:0] acq_cnt_q;
  logic        in_conv_q;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  sequence precharge_starts;
    !hold_to_rail ##1 hold_to_rail;
  endsequence

  sequence precharge_ends;
    hold_to_rail ##1 !hold_to_rail;
  endsequence

  // cycles spent acquiring before the converter is started; waits on the core are not counted
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acq_cnt_q <= '0;
      in_conv_q <= 1'b0;
    end
    else
    begin
      in_conv_q <= conv_start | (in_conv_q & ~conv_done);
      acq_cnt_q <= (hold_to_channel && !conv_start && !conv_done && !in_conv_q) ? acq_cnt_q + 14'h1 : 14'h0;
    end
  end

  a_rail_not_chan: assert property (hold_to_rail |-> !hold_to_channel)
    else $error("hold capacitor tied to rail and channel together");
  a_pre_pin_drive: assert property (hold_to_rail |-> pin_oe && pin_out == hold_rail_high)
    else $error("channel pin not forced to rail level in precharge");
  a_pin_released: assert property (!hold_to_rail |-> pin_oe == !pin_direction && pin_out == pin_port_data)
    else $error("channel pin still overridden outside precharge");
  a_acq_after_pre: assert property (precharge_ends |-> hold_to_channel && !conv_start)
    else $error("acquisition did not follow precharge");
  a_start_in_chan: assert property (conv_start |-> hold_to_channel && !hold_to_rail)
    else $error("conversion started without channel on hold capacitor");
  a_guards_match_pre: assert property (precharge_starts |-> guard_out_a == guard_out_b)
    else $error("guard outputs differ at precharge start");
  a_guard_a_flips: assert property (precharge_ends |-> guard_out_a != $past(guard_out_a) && $stable(guard_out_b))
    else $error("guard outputs wrong at acquisition start");
  a_guard_b_steady: assert property ($changed(guard_out_b) |-> $rose(hold_to_rail))
    else $error("guard b moved outside precharge start");
  a_acq_max_bound: assert property (acq_cnt_q <= 14'(ACQ_MAX))
    else $error("acquisition longer than the maximum");
endmodule

bind adcsc_top adcsc_top_assertions #(.ACQ_MAX(ACQ_MAX)) u_chk (.clock, .reset_n, .conv_start, .conv_done,
  .hold_to_rail, .hold_rail_high, .hold_to_channel, .pin_direction, .pin_port_data, .pin_out, .pin_oe,
  .guard_out_a, .guard_out_b);

// ### test/adcsc_conv_model.sv
// behavioural converter core answering each start pulse after a chosen latency
`timescale 1ns/1ps

module adcsc_conv_model
  import adcsc_pkg::*;
(
  // clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  // converter handshake
  input  wire logic             conv_start,
  output logic                  conv_done,
  output logic [RES_W-1:0]      conv_result,
  // bench control
  input  wire logic [3:0]       latency,
  input  wire logic [RES_W-1:0] sample
);
  logic [3:0]       wait_q;
  logic             busy_q;
  logic [RES_W-1:0] last_q;

  // result is only valid with done; otherwise show its inverse so a stale read is caught
  assign conv_result = conv_done ? last_q : ~last_q;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      busy_q <= 1'b0;
      wait_q <= '0;
      conv_done <= 1'b0;
      last_q <= '0;
    end
    else
    begin
      conv_done <= 1'b0;
      if (conv_start)
      begin
        last_q <= sample;
        busy_q <= latency > 4'h1;
        wait_q <= latency - 4'h1;
        conv_done <= latency <= 4'h1;
      end
      else if (busy_q)
      begin
        wait_q <= wait_q - 4'h1;
        busy_q <= wait_q > 4'h1;
        conv_done <= wait_q <= 4'h1;
      end
    end
  end
endmodule

// ### test/adcsc_top_tb.sv
// self-checking bench of the converter sequencer and compute block
`timescale 1ns/1ps

module adcsc_top_tb;
  import adcsc_pkg::*;
  localparam int ACQ_SIM = 20;
  logic             clock, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, rd;
  logic             special_trigger, conv_start, conv_done, g;
  logic [RES_W-1:0] conv_result, sample, s;
  logic             hold_to_rail, hold_rail_high, hold_to_channel;
  logic             pin_direction, pin_port_data, pin_out, pin_oe, guard_out_a, guard_out_b;
  logic [3:0]       latency;
  logic [33:0]      exp_rd[$], exp_pre[$], exp_acq[$], exp_grd[$], e;
  logic [15:0]      pre_n, acq_n;
  logic [17:0]      acc_e;
  logic [7:0]       cnt_e;
  logic [12:0]      pt[5] = '{13'h2, 13'h0, 13'h0, 13'h5, 13'h1};
  logic [12:0]      at[5] = '{13'h3, 13'h4, 13'h0, 13'h0, 13'h1};
  logic [7:0]       rst_tab[7] = '{OFF_CTRL0, OFF_CTRL1, OFF_CTRL2, OFF_PRE, OFF_ACQ, OFF_RPT, OFF_STATUS};
  int               mismatches = 0;
  int               n_checks = 0;

  adcsc_top #(.ACQ_MAX(ACQ_SIM)) dut (.clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .prdata, .special_trigger, .conv_start, .conv_done, .conv_result, .hold_to_rail, .hold_rail_high,
    .hold_to_channel, .pin_direction, .pin_port_data, .pin_out, .pin_oe, .guard_out_a, .guard_out_b);
  adcsc_conv_model model (.clock, .reset_n, .conv_start, .conv_done, .conv_result, .latency, .sample);

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock)
  begin
    pin_direction <= 1'($urandom);
    pin_port_data <= 1'($urandom);
  end

  task automatic chk(input logic [33:0] got, input logic [33:0] want);
    n_checks++;
    if (got !== want)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] x);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w)
      exp_rd.push_back(x);
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, '0);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [32:0] v);
    apb(1'b0, a, '0, {1'b1, v});
  endtask

  // start n samples and note the phase lengths and guard levels that each must show
  task automatic run(input int n, input logic [12:0] p, input logic [12:0] a, input logic [2:0] g1,
                     input logic [2:0] g2, input logic trig);
    for (int i = 0; i < n; i++)
    begin
      if (p != 0)
        exp_pre.push_back(34'(p));
      if (p != 0)
        exp_grd.push_back(34'(i == 1 ? g2 : g1));
      exp_acq.push_back(34'(a != 0 ? 16'(a) : (p != 0 ? 16'(ACQ_SIM) : 16'h0)));
    end
    latency <= 4'(1 + $urandom % 9);
    if (trig)
    begin
      @(posedge clock);
      special_trigger <= 1'b1;
      @(posedge clock);
      special_trigger <= 1'b0;
    end
    else
      wr(OFF_CTRL0, 32'h1);
    do
      apb(1'b0, OFF_STATUS, '0, '0);
    while (rd[STAT_BUSY_BIT] !== 1'b0);
  endtask

  always @(posedge clock)
  begin
    if (psel && penable && pready && !pwrite)
    begin
      e = exp_rd.pop_front();
      if (e[33])
        chk(34'({pslverr, prdata}), 34'(e[32:0]));
    end
    if (hold_to_rail && pre_n == 0)
      chk(34'({guard_out_a, guard_out_b, hold_rail_high}), exp_grd.pop_front());
    if (!hold_to_rail && pre_n != 0)
      chk(34'(pre_n), exp_pre.pop_front());
    pre_n = hold_to_rail ? pre_n + 16'h1 : 16'h0;
    if (conv_start)
      chk(34'(acq_n), exp_acq.pop_front());
    acq_n = (hold_to_channel && !conv_start && !conv_done) ? acq_n + 16'h1 : 16'h0;
  end

  initial
  begin
    #200000;
    mismatches++;
    end_sim();
  end

  initial
  begin
    void'($urandom(32'h8D61));
    {psel, penable, pwrite, special_trigger} = '0;
    paddr = '0;
    pwdata = '0;
    sample = 12'h1;
    latency = 4'h1;
    pre_n = '0;
    acq_n = '0;
    reset_n = 1'b0;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    foreach (rst_tab[i]) rd_chk(rst_tab[i], 33'h0);
    rd_chk(8'h30, {1'b1, 32'h0});
    wr(OFF_COUNT, 32'h55);
    rd_chk(OFF_COUNT, 33'h0);
    // phase lengths, skipped phases and both ways to start
    for (int i = 0; i < 5; i++)
    begin
      g = 1'($urandom);
      s = 1'($urandom);
      wr(OFF_CTRL1, {30'h0, g, s[0]});
      wr(OFF_PRE, 32'(pt[i]));
      wr(OFF_ACQ, 32'(at[i]));
      wr(OFF_CTRL0, {30'h0, i == 3, 1'b0});
      sample <= 12'($urandom) | 12'h1;
      run(1, pt[i], at[i], {g, g, s[0]}, {g, g, s[0]}, i == 3);
      rd_chk(OFF_STATUS, 33'h1);
      rd_chk(OFF_RESULT, {21'h0, sample});
      wr(OFF_STATUS, 32'h3);
    end
    // double sample with inverted second guard phase
    wr(OFF_CTRL1, 32'hD);
    wr(OFF_PRE, 32'h2);
    wr(OFF_ACQ, 32'h2);
    run(2, 13'h2, 13'h2, 3'b001, 3'b111, 1'b0);
    rd_chk(OFF_STATUS, 33'h9);
    wr(OFF_STATUS, 32'h3);
    // every compute mode and one unused code, three triggers each, threshold above zero
    wr(OFF_CTRL1, 32'h0);
    wr(OFF_PRE, 32'h1);
    wr(OFF_ACQ, 32'h1);
    wr(OFF_RPT, 32'h2);
    for (int m = 0; m < 6; m++)
    begin
      wr(OFF_CTRL2, {21'h0, 3'h1, 1'b0, THR_ABOVE, 1'b0, 3'(m)});
      wr(OFF_ACC, 32'h0);
      acc_e = '0;
      cnt_e = '0;
      for (int t = 0; t < 3; t++)
      begin
        s = 12'($urandom) | 12'h1;
        sample <= s;
        run(m == 3 ? 2 : 1, 13'h1, 13'h1, 3'b000, 3'b000, 1'b0);
        if ((m == 2 && cnt_e >= 8'h2) || m == 3)
        begin
          acc_e = '0;
          cnt_e = '0;
        end
        if (m != 5)
          acc_e = (m == 4) ? acc_e - (acc_e >> 1) + 18'(s) : acc_e + 18'(s) + (m == 3 ? 18'(s) : 18'h0);
        cnt_e = cnt_e + (m == 3 ? 8'h2 : 8'(m != 5));
        rd_chk(OFF_STATUS, {31'h0, m < 2 || m == 3 || cnt_e >= 8'h2, m != 5});
        if (m != 0)
          rd_chk(OFF_ACC, 33'(acc_e));
        if (m != 0)
          rd_chk(OFF_COUNT, 33'(cnt_e));
        wr(OFF_STATUS, 32'h3);
      end
    end
    chk(34'(exp_pre.size() + exp_acq.size()), 34'h0);
    end_sim();
  end
endmodule
